// File: src/clk_synth_regs_pkg.sv
// Package with constants for the serial register bank of the clock synthesizer
package clk_synth_regs_pkg;
  // Serial slave address, seven bits
  localparam logic [6:0] DEV_ADDR = 7'h69;
  // Register indexes
  localparam logic [6:0] IDX_STRAP_STATUS = 7'h00;
  localparam logic [6:0] IDX_OUTPUT_ENABLE = 7'h01;
  localparam logic [6:0] IDX_DRIVE_MODE = 7'h02;
  // Values after reset
  localparam logic [7:0] STRAP_STATUS_RST = 8'h4c;
  localparam logic [7:0] OUTPUT_ENABLE_RST = 8'h7f;
  localparam logic [7:0] DRIVE_MODE_RST = 8'h00;
  // Writable bits of registers 1 and 2
  localparam logic [7:0] OUTPUT_ENABLE_WMASK = 8'hc7;
  localparam logic [7:0] DRIVE_MODE_WMASK = 8'hf8;
  // Field positions
  localparam int STRAP_LOW_BIT = 0;
  localparam int STRAP_HIGH_BIT = 1;
  localparam int SRC_HALT_SEL_BIT = 7;
  localparam int SRC_EN_BIT = 6;
  localparam int CPU_EN_LSB = 0;
  localparam int SRC_PD_MODE_BIT = 7;
  localparam int SRC_STOP_MODE_BIT = 6;
  localparam int CPU_PD_MODE_LSB = 3;
  // Command byte layout
  localparam int CMD_BYTE_OP_BIT = 7;
  // Bits in a byte
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Value of an unmapped index
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
endpackage

// File: src/sync_2ff.sv
// Two flip-flop synchroniser for level signals
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Level crossing
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule // sync_2ff

// File: src/clock_synth_smbus_ctrl_regs.sv
// Serial slave interface and control registers 0 to 2 of the clock synthesizer
// Function
// RULE_01: A byte write is start, address with write bit, command, data, stop, each byte acknowledged by the device.
// RULE_02: A command byte with top bit set selects byte access and its low seven bits give the register index.
// RULE_03: A byte read is address and command, repeated start, address with read bit, one data byte, host ack, stop.
// RULE_04: Each start or repeated start is followed by a seven-bit address and direction, answered only on a match.
// RULE_05: Register 0 bits 1 and 0 show the two frequency straps as latched at power-up.
// RULE_06: Register 1 bit 7 chooses whether the SRC pair is halted by the peripheral clock stop input.
// RULE_07: Register 1 bit 6 enables the SRC pair and bits 2 to 0 the CPU pairs, all reset to one.
// RULE_08: Register 2 bits 7, 5, 4 and 3 choose three-state in power-down for SRC and CPU pairs, reset zero.
// RULE_09: Register 2 bit 6 chooses three-state of the SRC pair while it is stopped, reset zero.
// RULE_10: The device answers the seven-bit address 1101001.
// RULE_11: The straps are captured when processor voltage good is first seen low and ignored afterwards.
// RULE_12: Reserved and strap bits are read-only and host writes to them are dropped.
// RULE_13: A written byte is committed only after its eight bits are received and acknowledged.
`timescale 1ns/1ps
module clock_synth_smbus_ctrl_regs (
  // Core clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Serial link
  input wire logic i_link_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Straps and system controls
  input wire logic i_freq_strap_low,
  input wire logic i_freq_strap_high,
  input wire logic i_proc_volt_good_n,
  input wire logic i_periph_clk_halt_n,
  input wire logic i_power_down,
  // Output pair controls and strap latch flag
  output logic o_serial_ref_clk_run,
  output logic o_serial_ref_clk_drive,
  output logic [2:0] o_host_clk_drive,
  output logic o_straps_latched
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK, ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } link_state_t;

  function automatic logic [7:0] merge_write(input logic [7:0] cur, input logic [7:0] wr, input logic [7:0] mask);
    merge_write = (cur & ~mask) | (wr & mask);
  endfunction

  // Link domain reset, released on the link clock
  logic lrst_meta_r;
  logic lrst_r;
  always_ff @(posedge i_link_clk or posedge i_reset) begin
    if (i_reset) begin
      lrst_meta_r <= 1'b1;
      lrst_r <= 1'b1;
    end else begin
      lrst_meta_r <= 1'b0;
      lrst_r <= lrst_meta_r;
    end
  end

  // Line synchronisers and edge detection
  logic [1:0] line_s;
  logic scl_s;
  logic sda_s;
  logic scl_d_r;
  logic sda_d_r;
  sync_2ff #(.WIDTH(2)) u_line_sync (
    .i_clk(i_link_clk),
    .i_reset(lrst_r),
    .i_async({i_scl, i_sda}),
    .o_sync(line_s)
  );
  assign scl_s = line_s[1];
  assign sda_s = line_s[0];
  always_ff @(posedge i_link_clk or posedge lrst_r) begin
    if (lrst_r) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_det = scl_s && scl_d_r && !sda_d_r && sda_s;
  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;

  // Link request handshake towards the core
  logic req_tgl_r;
  logic req_wr_r;
  logic [6:0] req_idx_r;
  logic [7:0] req_wdata_r;
  logic ack_tgl_r;
  logic [7:0] rdata_r;
  logic ack_tgl_s;
  logic ack_seen_r;
  logic [7:0] rd_hold_r;

  sync_2ff #(.WIDTH(1)) u_ack_sync (
    .i_clk(i_link_clk),
    .i_reset(lrst_r),
    .i_async(ack_tgl_r),
    .o_sync(ack_tgl_s)
  );
  always_ff @(posedge i_link_clk or posedge lrst_r) begin
    if (lrst_r) begin
      ack_seen_r <= 1'b0;
      rd_hold_r <= clk_synth_regs_pkg::UNMAPPED_VALUE;
    end else begin
      ack_seen_r <= ack_tgl_s;
      if (ack_tgl_s != ack_seen_r) begin
        rd_hold_r <= rdata_r;
      end
    end
  end

  // Serial slave engine
  link_state_t state_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic dir_rd_r;
  always_ff @(posedge i_link_clk or posedge lrst_r) begin
    if (lrst_r) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      dir_rd_r <= 1'b0;
      o_sda_oe <= 1'b0;
      o_sda_out <= 1'b0;
      req_tgl_r <= 1'b0;
      req_wr_r <= 1'b0;
      req_idx_r <= 7'h00;
      req_wdata_r <= 8'h00;
    end else if (start_det) begin
      state_r <= ST_ADDR; // RULE_04
      cnt_r <= 4'h0;
      o_sda_oe <= 1'b0;
    end else if (stop_det) begin
      state_r <= ST_IDLE;
      o_sda_oe <= 1'b0;
    end else if (scl_rise) begin
      unique case (state_r)
        ST_ADDR, ST_CMD, ST_WDATA: begin
          shift_r <= {shift_r[6:0], sda_s};
          cnt_r <= cnt_r + 4'h1;
        end
        ST_RDATA: begin
          cnt_r <= cnt_r + 4'h1;
        end
        ST_RDATA_ACK: begin
          state_r <= ST_IDLE; // RULE_03
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (state_r)
        ST_ADDR: begin
          if (cnt_r == clk_synth_regs_pkg::BYTE_BITS) begin
            if (shift_r[7:1] == clk_synth_regs_pkg::DEV_ADDR) begin // RULE_10
              o_sda_oe <= 1'b1; // RULE_04
              dir_rd_r <= shift_r[0];
              state_r <= ST_ADDR_ACK;
            end else begin
              state_r <= ST_IDLE; // RULE_04
            end
          end
        end
        ST_ADDR_ACK: begin
          cnt_r <= 4'h0;
          if (dir_rd_r) begin
            tx_r <= rd_hold_r; // RULE_03
            o_sda_oe <= !rd_hold_r[7];
            state_r <= ST_RDATA;
          end else begin
            o_sda_oe <= 1'b0;
            state_r <= ST_CMD; // RULE_01
          end
        end
        ST_CMD: begin
          if (cnt_r == clk_synth_regs_pkg::BYTE_BITS) begin
            if (shift_r[clk_synth_regs_pkg::CMD_BYTE_OP_BIT]) begin // RULE_02
              o_sda_oe <= 1'b1;
              req_idx_r <= shift_r[6:0];
              req_wr_r <= 1'b0;
              req_tgl_r <= !req_tgl_r; // RULE_03
              state_r <= ST_CMD_ACK;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_CMD_ACK: begin
          o_sda_oe <= 1'b0;
          cnt_r <= 4'h0;
          state_r <= ST_WDATA;
        end
        ST_WDATA: begin
          if (cnt_r == clk_synth_regs_pkg::BYTE_BITS) begin
            o_sda_oe <= 1'b1; // RULE_01
            req_wdata_r <= shift_r;
            state_r <= ST_WDATA_ACK;
          end
        end
        ST_WDATA_ACK: begin
          o_sda_oe <= 1'b0;
          req_wr_r <= 1'b1;
          req_tgl_r <= !req_tgl_r; // RULE_13
          state_r <= ST_IDLE;
        end
        ST_RDATA: begin
          if (cnt_r == clk_synth_regs_pkg::BYTE_BITS) begin
            o_sda_oe <= 1'b0;
            state_r <= ST_RDATA_ACK;
          end else begin
            tx_r <= {tx_r[6:0], 1'b0};
            o_sda_oe <= !tx_r[6];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Core domain: request crossing
  logic req_tgl_s;
  logic req_seen_r;
  sync_2ff #(.WIDTH(1)) u_req_sync (
    .i_clk(i_mclk),
    .i_reset(i_reset),
    .i_async(req_tgl_r),
    .o_sync(req_tgl_s)
  );
  logic req_new;
  assign req_new = req_tgl_s != req_seen_r;

  // Core domain: strap and control input synchronisers
  logic [4:0] ctl_s;
  sync_2ff #(.WIDTH(5)) u_ctl_sync (
    .i_clk(i_mclk),
    .i_reset(i_reset),
    .i_async({i_freq_strap_low, i_freq_strap_high, i_proc_volt_good_n, i_periph_clk_halt_n, i_power_down}),
    .o_sync(ctl_s)
  );
  logic vgood_n_s;
  logic halt_n_s;
  logic pd_s;
  assign vgood_n_s = ctl_s[2];
  assign halt_n_s = ctl_s[1];
  assign pd_s = ctl_s[0];

  // Strap capture, one shot
  logic [1:0] straps_r;
  logic vgood_armed_r;
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      straps_r <= 2'b00;
      o_straps_latched <= 1'b0;
      vgood_armed_r <= 1'b0;
    end else begin
      if (vgood_n_s) begin
        vgood_armed_r <= 1'b1;
      end
      if (vgood_armed_r && !vgood_n_s && !o_straps_latched) begin
        straps_r <= {ctl_s[3], ctl_s[4]}; // RULE_11
        o_straps_latched <= 1'b1; // RULE_11
      end
    end
  end

  // Control registers
  logic [7:0] out_en_r;
  logic [7:0] drive_mode_r;
  logic [7:0] strap_status;
  assign strap_status = {clk_synth_regs_pkg::STRAP_STATUS_RST[7:2], straps_r}; // RULE_05 RULE_12
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      out_en_r <= clk_synth_regs_pkg::OUTPUT_ENABLE_RST; // RULE_07
      drive_mode_r <= clk_synth_regs_pkg::DRIVE_MODE_RST; // RULE_08 RULE_09
    end else if (req_new && req_wr_r) begin
      if (req_idx_r == clk_synth_regs_pkg::IDX_OUTPUT_ENABLE) begin
        out_en_r <= merge_write(out_en_r, req_wdata_r, clk_synth_regs_pkg::OUTPUT_ENABLE_WMASK); // RULE_12
      end
      if (req_idx_r == clk_synth_regs_pkg::IDX_DRIVE_MODE) begin
        drive_mode_r <= merge_write(drive_mode_r, req_wdata_r, clk_synth_regs_pkg::DRIVE_MODE_WMASK); // RULE_12
      end
    end
  end

  // Read answer and acknowledge toggle
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      req_seen_r <= 1'b0;
      ack_tgl_r <= 1'b0;
      rdata_r <= clk_synth_regs_pkg::UNMAPPED_VALUE;
    end else begin
      req_seen_r <= req_tgl_s;
      if (req_new) begin
        ack_tgl_r <= !ack_tgl_r;
        if (req_idx_r == clk_synth_regs_pkg::IDX_STRAP_STATUS) begin
          rdata_r <= strap_status; // RULE_05
        end else if (req_idx_r == clk_synth_regs_pkg::IDX_OUTPUT_ENABLE) begin
          rdata_r <= out_en_r;
        end else if (req_idx_r == clk_synth_regs_pkg::IDX_DRIVE_MODE) begin
          rdata_r <= drive_mode_r;
        end else begin
          rdata_r <= clk_synth_regs_pkg::UNMAPPED_VALUE;
        end
      end
    end
  end

  // Output pair controls
  logic src_halted;
  assign src_halted = !halt_n_s && out_en_r[clk_synth_regs_pkg::SRC_HALT_SEL_BIT];
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_serial_ref_clk_run <= 1'b1;
      o_serial_ref_clk_drive <= 1'b1;
      o_host_clk_drive <= 3'b111;
    end else begin
      o_serial_ref_clk_run <= !src_halted; // RULE_06
      o_serial_ref_clk_drive <= out_en_r[clk_synth_regs_pkg::SRC_EN_BIT] // RULE_07
        && !(pd_s && drive_mode_r[clk_synth_regs_pkg::SRC_PD_MODE_BIT]) // RULE_08
        && !(src_halted && drive_mode_r[clk_synth_regs_pkg::SRC_STOP_MODE_BIT]); // RULE_09
      o_host_clk_drive <= out_en_r[clk_synth_regs_pkg::CPU_EN_LSB +: 3] // RULE_07
        & ~({3{pd_s}} & drive_mode_r[clk_synth_regs_pkg::CPU_PD_MODE_LSB +: 3]); // RULE_08
    end
  end
endmodule // clock_synth_smbus_ctrl_regs

// File: verif/clock_synth_smbus_ctrl_regs_assertions.sv
// Port checker of the serial register bank
`timescale 1ns/1ps
module clock_synth_smbus_ctrl_regs_checker (
  // Clocks and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_link_clk,
  // Inputs watched
  input wire logic i_scl,
  input wire logic i_proc_volt_good_n,
  input wire logic i_periph_clk_halt_n,
  // Outputs watched
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_serial_ref_clk_run,
  input wire logic [2:0] o_host_clk_drive,
  input wire logic o_straps_latched
);
  sda_pull_only_a:
    assert property (@(posedge i_link_clk) disable iff (i_reset) o_sda_out == 1'b0) else $error("sda value");
  ack_rise_low_a:
    assert property (@(posedge i_link_clk) disable iff (i_reset) $rose(o_sda_oe) |-> !i_scl) else $error("oe rise");
  ack_steady_high_a:
    assert property (@(posedge i_link_clk) disable iff (i_reset) i_scl [*5] |-> $stable(o_sda_oe)) else $error("oe");
  reset_values_a:
    assert property (@(posedge i_mclk) disable iff (i_reset) $fell(i_reset) |-> o_host_clk_drive == 3'h7
      && !o_straps_latched && o_serial_ref_clk_run) else $error("reset values");
  latch_sticky_a:
    assert property (@(posedge i_mclk) disable iff (i_reset) o_straps_latched |=> o_straps_latched) else $error("latch");
  latch_cause_a:
    assert property (@(posedge i_mclk) disable iff (i_reset)
      $rose(o_straps_latched) |-> !$past(i_proc_volt_good_n, 2)) else $error("latch cause");
  run_free_a:
    assert property (@(posedge i_mclk) disable iff (i_reset)
      i_periph_clk_halt_n [*5] |-> o_serial_ref_clk_run) else $error("run free");
  run_halt_cause_a:
    assert property (@(posedge i_mclk) disable iff (i_reset) !o_serial_ref_clk_run
      |-> !$past(i_periph_clk_halt_n, 2) || !$past(i_periph_clk_halt_n, 3)) else $error("run halt");
  cover property (@(posedge i_link_clk) disable iff (i_reset) $rose(o_sda_oe));
  cover property (@(posedge i_mclk) disable iff (i_reset) $rose(o_straps_latched));
  cover property (@(posedge i_mclk) disable iff (i_reset) $fell(o_serial_ref_clk_run));
endmodule // clock_synth_smbus_ctrl_regs_checker
bind clock_synth_smbus_ctrl_regs clock_synth_smbus_ctrl_regs_checker chk_u (.i_mclk(i_mclk), .i_reset(i_reset),
  .i_link_clk(i_link_clk), .i_scl(i_scl), .i_proc_volt_good_n(i_proc_volt_good_n),
  .i_periph_clk_halt_n(i_periph_clk_halt_n), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .o_serial_ref_clk_run(o_serial_ref_clk_run), .o_host_clk_drive(o_host_clk_drive),
  .o_straps_latched(o_straps_latched));

// File: verif/smbus_host_model.sv
// Serial bus host model
`timescale 1ns/1ps
module smbus_host_model (
  // Clock and wire level
  input wire logic i_mclk,
  input wire logic i_sda,
  // Host drives
  output logic o_scl,
  output logic o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic half();
    repeat (3) @(negedge i_mclk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    o_sda_low = !b;
    half();
    o_scl = 1'b1;
    half();
    r = i_sda;
    o_scl = 1'b0;
    half();
  endtask
  task automatic start();
    o_sda_low = 1'b0;
    half();
    o_scl = 1'b1;
    half();
    o_sda_low = 1'b1;
    half();
    o_scl = 1'b0;
    half();
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    half();
    o_scl = 1'b1;
    half();
    o_sda_low = 1'b0;
    half();
  endtask
  task automatic xfer(input logic [7:0] t, input logic n, output logic [7:0] r, output logic k);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(t[i], b);
      r = {r[6:0], b};
    end
    bit_io(n, b);
    k = !b;
  endtask
  task automatic access(input logic [7:0] a, input logic rdq, input logic [7:0] c, input logic [7:0] d,
                        output logic [7:0] r, output logic [2:0] k);
    logic [7:0] j;
    start();
    xfer(a, 1'b1, j, k[2]);
    xfer(c, 1'b1, j, k[1]);
    r = 8'h00;
    if (rdq) begin
      start();
      xfer(a | 8'h01, 1'b1, j, k[0]);
      xfer(8'hff, 1'b0, r, j[0]);
    end else begin
      xfer(d, 1'b1, j, k[0]);
    end
    stop();
  endtask
  task automatic abort(input logic [7:0] a, input logic [7:0] c);
    logic [7:0] j;
    logic k;
    start();
    xfer(a, 1'b1, j, k);
    xfer(c, 1'b1, j, k);
    for (int i = 0; i < 4; i++) bit_io(1'b0, k);
    stop();
  endtask
endmodule // smbus_host_model

// File: verif/clock_synth_smbus_ctrl_regs_test.sv
// Self-checking bench of the serial register bank
`timescale 1ns/1ps
module clock_synth_smbus_ctrl_regs_test;
  localparam logic [7:0] AW = {clk_synth_regs_pkg::DEV_ADDR, 1'b0};
  logic i_mclk = 1'b0;
  logic link_clk = 1'b0;
  logic i_reset = 1'b1;
  logic s_lo = 1'b0, s_hi = 1'b0, vg_n = 1'b1, halt_n = 1'b1, pd = 1'b0, le = 1'b0;
  logic scl, sda_low, sda, oe, run, drv, lat;
  logic [2:0] hd, ak;
  logic [7:0] en = 8'h7f, md = 8'h00, rd, v;
  logic [12:0] exp_q[$];
  logic [12:0] head;
  int mismatches = 0, n_tests = 0;
  event seen;
  assign sda = !(sda_low || oe);
  initial forever #25 i_mclk = !i_mclk;
  initial begin
    #3;
    forever #7.5 link_clk = !link_clk;
  end
  smbus_host_model host_u (.i_mclk(i_mclk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  clock_synth_smbus_ctrl_regs dut_u (.i_mclk(i_mclk), .i_reset(i_reset), .i_link_clk(link_clk), .i_scl(scl),
    .i_sda(sda), .o_sda_out(), .o_sda_oe(oe), .i_freq_strap_low(s_lo), .i_freq_strap_high(s_hi),
    .i_proc_volt_good_n(vg_n), .i_periph_clk_halt_n(halt_n), .i_power_down(pd), .o_serial_ref_clk_run(run),
    .o_serial_ref_clk_drive(drv), .o_host_clk_drive(hd), .o_straps_latched(lat));
  task automatic conclude();
    if (mismatches == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic compare_bus(input logic [10:0] e, input logic [10:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic compare_pins(input logic [5:0] e, input logic [5:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic note(input logic k, input logic [11:0] e);
    exp_q.push_back({k, e});
    ->seen;
    #1;
  endtask
  task automatic acc(input logic [7:0] a, input logic q, input logic [7:0] c, input logic [7:0] d,
                     input logic [2:0] ea, input logic [7:0] ed);
    host_u.access(a, q, c, d, rd, ak);
    note(1'b0, {1'b0, ea, ed});
  endtask
  task automatic pins();
    logic h;
    h = !halt_n && en[7];
    repeat (8) @(negedge i_mclk);
    note(1'b1, {6'h0, !h, en[6] && !(pd && md[7]) && !(h && md[6]), en[2:0] & ~({3{pd}} & md[5:3]), le});
  endtask
  initial forever begin
    @(seen);
    head = exp_q.pop_front();
    if (head[12]) compare_pins(head[5:0], {run, drv, hd, lat});
    else compare_bus(head[10:0], {ak, rd});
  end
  initial begin
    #2000000;
    mismatches++;
    conclude();
  end
  initial begin
    void'($urandom(32'ha0ee));
    repeat (10) @(negedge i_mclk);
    i_reset = 1'b0;
    repeat (20) @(negedge i_mclk);
    pins();
    v = $urandom;
    s_lo = v[0];
    s_hi = v[1];
    repeat (4) @(negedge i_mclk);
    vg_n = 1'b0;
    le = 1'b1;
    repeat (6) @(negedge i_mclk);
    s_lo = !s_lo;
    pins();
    acc(AW, 1'b1, 8'h80, 8'h00, 3'h7, 8'h4c | {6'h0, v[1:0]});
    acc(AW, 1'b0, 8'h80, ~v, 3'h7, 8'h00);
    acc(AW, 1'b1, 8'h80, 8'h00, 3'h7, 8'h4c | {6'h0, v[1:0]});
    acc(AW, 1'b1, 8'h81, 8'h00, 3'h7, 8'h7f);
    acc(AW, 1'b1, 8'h82, 8'h00, 3'h7, 8'h00);
    for (int j = 0; j < 2; j++) begin
      v = $urandom;
      v[7] = j[0];
      acc(AW, 1'b0, 8'h81, v, 3'h7, 8'h00);
      en = (v & 8'hc7) | 8'h38;
      acc(AW, 1'b1, 8'h81, 8'h00, 3'h7, en);
      v = $urandom;
      v[7] = !j[0];
      v[6] = j[0];
      acc(AW, 1'b0, 8'h82, v, 3'h7, 8'h00);
      md = v & 8'hf8;
      acc(AW, 1'b1, 8'h82, 8'h00, 3'h7, md);
      for (int i = 0; i < 4; i++) begin
        pd = i[0];
        halt_n = !i[1];
        pins();
      end
    end
    acc(AW ^ 8'h02, 1'b0, 8'h81, 8'h00, 3'h0, 8'h00);
    acc(AW, 1'b0, 8'h01, 8'h00, 3'h4, 8'h00);
    acc(AW, 1'b0, 8'h85, 8'hff, 3'h7, 8'h00);
    acc(AW, 1'b1, 8'h85, 8'h00, 3'h7, 8'h00);
    host_u.abort(AW, 8'h81);
    acc(AW, 1'b1, 8'h81, 8'h00, 3'h7, en);
    repeat (4) @(negedge i_mclk);
    conclude();
  end
endmodule // clock_synth_smbus_ctrl_regs_test
